/* sfe_frontend.sv */
`timescale 1ns/100ps
`default_nettype none

module sfe_frontend import sfe_pkg::*; #(
  parameter int PIX_W = 24
) (
  // Register side clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Subaddress write port
  input  wire logic             reg_wr_en,
  input  wire logic [7:0]       reg_subaddr,
  input  wire logic [7:0]       reg_wdata,
  // Video input link
  input  wire logic             vclk,
  input  wire logic             line_sync_input_pin,
  input  wire logic             frame_sync_input_pin,
  input  wire logic [PIX_W-1:0] adc0_data,
  input  wire logic [PIX_W-1:0] adc1_data,
  // Analogue front end pulses
  output var  logic             clamp_pulse,
  output var  logic             gain_correction_pulse,
  // Captured pixels
  output var  logic [PIX_W-1:0] pixel_data,
  output var  logic             pixel_valid,
  output var  logic             pixel_from_adc1
);

  if (PIX_W < 1) begin : g_bad_pix_w
    $error("sfe_frontend: PIX_W must be at least 1");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic in_window(input logic [SFE_HW-1:0] cnt,
                                     input logic [SFE_HW-1:0] off,
                                     input logic [SFE_HW-1:0] len);
    logic [SFE_HW:0] stop;
    stop = {1'b0, off} + {1'b0, len};
    return ({1'b0, cnt} >= {1'b0, off}) && ({1'b0, cnt} < stop);
  endfunction

  function automatic logic [SFE_HW-1:0] sat_inc(input logic [SFE_HW-1:0] v);
    return (v == {SFE_HW{1'b1}}) ? v : v + 12'h001;
  endfunction

  // ----------------------------------------------------------------
  // Register bank (ref_clk)
  // ----------------------------------------------------------------
  logic [7:0]        gen_ctrl_q;
  logic [SFE_VW-1:0] voff_q;
  logic [SFE_HW-1:0] hoff_q;
  logic [SFE_VW-1:0] vlen_q;
  logic [SFE_HW-1:0] hlen_q;
  logic [7:0]        clamp_st_q;
  logic [7:0]        clamp_end_q;
  logic [7:0]        gain_st_q;
  logic [7:0]        gain_end_q;

  wire wr_gen   = reg_wr_en && (reg_subaddr == SFE_ADDR_GEN_CTRL);
  wire wr_vo_lo = reg_wr_en && (reg_subaddr == SFE_ADDR_VOFF_LO);
  wire wr_vo_hi = reg_wr_en && (reg_subaddr == SFE_ADDR_VOFF_HI);
  wire wr_ho_lo = reg_wr_en && (reg_subaddr == SFE_ADDR_HOFF_LO);
  wire wr_ho_hi = reg_wr_en && (reg_subaddr == SFE_ADDR_HOFF_HI);
  wire wr_vl_lo = reg_wr_en && (reg_subaddr == SFE_ADDR_VLEN_LO);
  wire wr_vl_hi = reg_wr_en && (reg_subaddr == SFE_ADDR_VLEN_HI);
  wire wr_hl_lo = reg_wr_en && (reg_subaddr == SFE_ADDR_HLEN_LO);
  wire wr_hl_hi = reg_wr_en && (reg_subaddr == SFE_ADDR_HLEN_HI);
  wire wr_cs    = reg_wr_en && (reg_subaddr == SFE_ADDR_CLAMP_ST);
  wire wr_ce    = reg_wr_en && (reg_subaddr == SFE_ADDR_CLAMP_END);
  wire wr_gs    = reg_wr_en && (reg_subaddr == SFE_ADDR_GAIN_ST);
  wire wr_ge    = reg_wr_en && (reg_subaddr == SFE_ADDR_GAIN_END);
  wire wr_any   = wr_gen | wr_vo_lo | wr_vo_hi | wr_ho_lo | wr_ho_hi | wr_vl_lo | wr_vl_hi
                | wr_hl_lo | wr_hl_hi | wr_cs | wr_ce | wr_gs | wr_ge;

  // Low byte at the lower subaddress, upper bits at the next one
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gen_ctrl_q  <= SFE_RST_GEN_CTRL;
      voff_q      <= SFE_RST_V;
      hoff_q      <= SFE_RST_H;
      vlen_q      <= SFE_RST_V;
      hlen_q      <= SFE_RST_H;
      clamp_st_q  <= SFE_RST_PULSE;
      clamp_end_q <= SFE_RST_PULSE;
      gain_st_q   <= SFE_RST_PULSE;
      gain_end_q  <= SFE_RST_PULSE;
    end else begin
      if (wr_gen)   gen_ctrl_q          <= reg_wdata;
      if (wr_vo_lo) voff_q[7:0]         <= reg_wdata;
      if (wr_vo_hi) voff_q[SFE_VW-1:8]  <= reg_wdata[2:0];
      if (wr_ho_lo) hoff_q[7:0]         <= reg_wdata;
      if (wr_ho_hi) hoff_q[SFE_HW-1:8]  <= reg_wdata[3:0];
      if (wr_vl_lo) vlen_q[7:0]         <= reg_wdata;
      if (wr_vl_hi) vlen_q[SFE_VW-1:8]  <= reg_wdata[2:0];
      if (wr_hl_lo) hlen_q[7:0]         <= reg_wdata;
      if (wr_hl_hi) hlen_q[SFE_HW-1:8]  <= reg_wdata[3:0];
      if (wr_cs)    clamp_st_q          <= reg_wdata;
      if (wr_ce)    clamp_end_q         <= reg_wdata;
      if (wr_gs)    gain_st_q           <= reg_wdata;
      if (wr_ge)    gain_end_q          <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Settings crossing: snapshot held stable until acknowledged
  // ----------------------------------------------------------------
  logic [SFE_CFG_W-1:0] snap_q;
  logic                 dirty_q;
  logic                 req_q;
  logic                 ack_ref;
  wire  [SFE_CFG_W-1:0] bank = {gen_ctrl_q, voff_q, hoff_q, vlen_q, hlen_q,
                                clamp_st_q, clamp_end_q, gain_st_q, gain_end_q};
  wire                  xfer_idle = (req_q == ack_ref);
  wire                  launch    = xfer_idle && dirty_q;

  // New write keeps dirty set even while a launch takes it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      snap_q  <= '0;
      dirty_q <= 1'b1;
      req_q   <= 1'b0;
    end else begin
      dirty_q <= wr_any | (dirty_q & ~launch);
      if (launch) begin
        snap_q <= bank;
        req_q  <= ~req_q;
      end
    end
  end

  logic req_v;
  logic ack_q;

  sfe_sync2 #(.W(1)) u_req_sync (
    .clk   (vclk),
    .rst_n (rst_n),
    .d     (req_q),
    .q     (req_v)
  );

  sfe_sync2 #(.W(1)) u_ack_sync (
    .clk   (ref_clk),
    .rst_n (rst_n),
    .d     (ack_q),
    .q     (ack_ref)
  );

  // ----------------------------------------------------------------
  // Link side settings (vclk)
  // ----------------------------------------------------------------
  logic [SFE_CFG_W-1:0] cfg_q;
  wire                  take_cfg = (req_v != ack_q);

  // Snapshot is static while req and ack differ
  always_ff @(posedge vclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= '0;
      ack_q <= 1'b0;
    end else if (take_cfg) begin
      cfg_q <= snap_q;
      ack_q <= req_v;
    end
  end

  wire [7:0]        c_gen;
  wire [SFE_VW-1:0] c_voff;
  wire [SFE_HW-1:0] c_hoff;
  wire [SFE_VW-1:0] c_vlen;
  wire [SFE_HW-1:0] c_hlen;
  wire [7:0]        c_cst;
  wire [7:0]        c_cend;
  wire [7:0]        c_gst;
  wire [7:0]        c_gend;

  assign {c_gen, c_voff, c_hoff, c_vlen, c_hlen, c_cst, c_cend, c_gst, c_gend} = cfg_q;

  // ----------------------------------------------------------------
  // Pin capture (vclk)
  // ----------------------------------------------------------------
  logic [1:0]       sync_s;
  logic [PIX_W-1:0] adc0_s;
  logic [PIX_W-1:0] adc1_s;

  sfe_sync2 #(.W(2)) u_sync_pins (
    .clk   (vclk),
    .rst_n (rst_n),
    .d     ({frame_sync_input_pin, line_sync_input_pin}),
    .q     (sync_s)
  );

  sfe_sync2 #(.W(2 * PIX_W)) u_adc_pins (
    .clk   (vclk),
    .rst_n (rst_n),
    .d     ({adc1_data, adc0_data}),
    .q     ({adc1_s, adc0_s})
  );

  // Sync asserted level per polarity bit
  wire hs_act = c_gen[SFE_BIT_HS_POL] ? sync_s[0] : ~sync_s[0];
  wire vs_act = c_gen[SFE_BIT_VS_POL] ? sync_s[1] : ~sync_s[1];

  logic       hs_prev_q;
  logic       vs_prev_q;
  logic [2:0] arm_q;

  // Edges held off until pin stages and history hold real levels,
  // otherwise the zero reset state fakes a sync edge
  always_ff @(posedge vclk or negedge rst_n) begin
    if (!rst_n) begin
      hs_prev_q <= 1'b0;
      vs_prev_q <= 1'b0;
      arm_q     <= 3'h0;
    end else begin
      hs_prev_q <= hs_act;
      vs_prev_q <= vs_act;
      arm_q     <= {arm_q[1:0], 1'b1};
    end
  end

  wire armed    = arm_q[2];
  wire hs_lead  = armed & hs_act & ~hs_prev_q;
  wire hs_trail = armed & ~hs_act & hs_prev_q;
  wire vs_trail = armed & ~vs_act & vs_prev_q;

  // ----------------------------------------------------------------
  // Counters: cycles from either sync edge, lines from frame start
  // ----------------------------------------------------------------
  logic [SFE_HW-1:0] lead_cnt_q;
  logic [SFE_HW-1:0] pix_cnt_q;
  logic [SFE_VW-1:0] line_cnt_q;
  logic              lead_seen_q;
  logic              trail_seen_q;

  // Saturating so a missing sync cannot wrap into a new window
  always_ff @(posedge vclk or negedge rst_n) begin
    if (!rst_n) begin
      lead_cnt_q   <= '0;
      pix_cnt_q    <= '0;
      line_cnt_q   <= '0;
      lead_seen_q  <= 1'b0;
      trail_seen_q <= 1'b0;
    end else begin
      lead_cnt_q   <= hs_lead ? '0 : sat_inc(lead_cnt_q);
      pix_cnt_q    <= hs_trail ? '0 : sat_inc(pix_cnt_q);
      lead_seen_q  <= lead_seen_q | hs_lead;
      trail_seen_q <= trail_seen_q | hs_trail;
      if (vs_trail)
        line_cnt_q <= '0;
      else if (hs_trail && line_cnt_q != {SFE_VW{1'b1}})
        line_cnt_q <= line_cnt_q + 11'h001;
    end
  end

  // ----------------------------------------------------------------
  // Sampling window and converter order
  // ----------------------------------------------------------------
  wire v_open = in_window({1'b0, line_cnt_q}, {1'b0, c_voff}, {1'b0, c_vlen});
  wire h_open = trail_seen_q && in_window(pix_cnt_q, c_hoff, c_hlen);
  wire take   = c_gen[SFE_BIT_IN_EN] && v_open && h_open;
  wire use1   = c_gen[SFE_BIT_ADC_SEQ] ^ pix_cnt_q[0];

  always_ff @(posedge vclk or negedge rst_n) begin
    if (!rst_n) begin
      pixel_data      <= '0;
      pixel_valid     <= 1'b0;
      pixel_from_adc1 <= 1'b0;
    end else begin
      pixel_valid <= take;
      if (take) begin
        pixel_data      <= use1 ? adc1_s : adc0_s;
        pixel_from_adc1 <= use1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clamp and gain-correction pulses
  // ----------------------------------------------------------------
  wire clamp_set = lead_seen_q && (lead_cnt_q == {4'h0, c_cst});
  wire clamp_clr = lead_seen_q && (lead_cnt_q == {4'h0, c_cend});
  wire gain_set  = lead_seen_q && (lead_cnt_q == {4'h0, c_gst});
  wire gain_clr  = trail_seen_q && (pix_cnt_q == {4'h0, c_gend});

  sfe_pulse_gen u_clamp (
    .clk         (vclk),
    .rst_n       (rst_n),
    .set_hit     (clamp_set),
    .clr_hit     (clamp_clr),
    .active_high (c_gen[SFE_BIT_CLAMP_POL]),
    .pulse_out   (clamp_pulse)
  );

  sfe_pulse_gen u_gain (
    .clk         (vclk),
    .rst_n       (rst_n),
    .set_hit     (gain_set),
    .clr_hit     (gain_clr),
    .active_high (c_gen[SFE_BIT_GAIN_POL]),
    .pulse_out   (gain_correction_pulse)
  );

endmodule

`default_nettype wire

/* sfe_frontend_assertions.sv */
`timescale 1ns/100ps
`default_nettype none

module sfe_frontend_assertions import sfe_pkg::*; #(
  parameter int PIX_W = 24
) (
  // Register side
  input wire logic             ref_clk,
  input wire logic             rst_n,
  input wire logic             reg_wr_en,
  input wire logic [7:0]       reg_subaddr,
  input wire logic [7:0]       reg_wdata,
  // Link side
  input wire logic             vclk,
  input wire logic             line_sync_input_pin,
  input wire logic             frame_sync_input_pin,
  input wire logic [PIX_W-1:0] adc0_data,
  input wire logic [PIX_W-1:0] adc1_data,
  input wire logic             clamp_pulse,
  input wire logic             gain_correction_pulse,
  input wire logic [PIX_W-1:0] pixel_data,
  input wire logic             pixel_valid,
  input wire logic             pixel_from_adc1
);
  // ----------------
  // Shadow and runs
  // ----------------
  logic [7:0]  ctl_q, cst_q, cen_q, gst_q, gen_q, ld_q, hs_q, hw_q, cr_q, gr_q;
  logic [11:0] hof_q, hln_q, vr_q;
  logic [5:0]  qt_q;
  logic        hs_p;
  // Settings need a few link cycles to cross, so checks wait for quiet
  wire calm   = qt_q == 6'h3f;
  wire hs_act = line_sync_input_pin == ctl_q[0];
  wire cl_act = clamp_pulse == ctl_q[2];
  wire ga_act = gain_correction_pulse == ctl_q[3];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {ctl_q, cst_q, cen_q, gst_q, gen_q, hof_q, hln_q} <= '0;
    end else if (reg_wr_en) begin
      case (reg_subaddr)
        SFE_ADDR_GEN_CTRL:  ctl_q <= reg_wdata;
        SFE_ADDR_HOFF_LO:   hof_q[7:0] <= reg_wdata;
        SFE_ADDR_HOFF_HI:   hof_q[11:8] <= reg_wdata[3:0];
        SFE_ADDR_HLEN_LO:   hln_q[7:0] <= reg_wdata;
        SFE_ADDR_HLEN_HI:   hln_q[11:8] <= reg_wdata[3:0];
        SFE_ADDR_CLAMP_ST:  cst_q <= reg_wdata;
        SFE_ADDR_CLAMP_END: cen_q <= reg_wdata;
        SFE_ADDR_GAIN_ST:   gst_q <= reg_wdata;
        SFE_ADDR_GAIN_END:  gen_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) qt_q <= 6'h00;
    else if (reg_wr_en) qt_q <= 6'h00;
    else if (!calm) qt_q <= qt_q + 6'h01;
  end

  always_ff @(posedge vclk or negedge rst_n) begin
    if (!rst_n) begin
      {hs_p, ld_q, hs_q, hw_q, cr_q, gr_q, vr_q} <= {1'b0, 8'hff, 32'h0, 12'h000};
    end else begin
      hs_p <= hs_act;
      ld_q <= (hs_act && !hs_p) ? 8'h00 : ld_q + {7'h00, ld_q != 8'hff};
      hs_q <= hs_act ? hs_q + 8'h01 : 8'h00;
      hw_q <= (hs_p && !hs_act) ? hs_q : hw_q;
      cr_q <= cl_act ? cr_q + 8'h01 : 8'h00;
      gr_q <= ga_act ? gr_q + 8'h01 : 8'h00;
      vr_q <= pixel_valid ? vr_q + 12'h001 : 12'h000;
    end
  end

  // ----------------
  // Properties
  // ----------------
  a_clamp_start: assert property (@(posedge vclk) disable iff (!rst_n)
    calm && $rose(cl_act) |-> ld_q >= cst_q + 8'd2 && ld_q <= cst_q + 8'd8)
    else $error("clamp start off");
  a_clamp_width: assert property (@(posedge vclk) disable iff (!rst_n)
    calm && $fell(cl_act) |-> cr_q == cen_q - cst_q) else $error("clamp width");
  a_gain_width: assert property (@(posedge vclk) disable iff (!rst_n)
    calm && $fell(ga_act) |-> gr_q == hw_q + gen_q - gst_q) else $error("gain width");
  a_idle_levels: assert property (@(posedge vclk) disable iff (!rst_n)
    calm && ld_q == 8'hff |-> clamp_pulse != ctl_q[2] && gain_correction_pulse != ctl_q[3])
    else $error("pulse idle level");
  a_valid_run: assert property (@(posedge vclk) disable iff (!rst_n)
    calm && $fell(pixel_valid) |-> vr_q == hln_q) else $error("window length");
  a_first_source: assert property (@(posedge vclk) disable iff (!rst_n)
    calm && $rose(pixel_valid) |-> pixel_from_adc1 == (ctl_q[4] ^ hof_q[0]))
    else $error("first converter");
  a_source_turns: assert property (@(posedge vclk) disable iff (!rst_n)
    calm && pixel_valid && $past(pixel_valid) |-> pixel_from_adc1 != $past(pixel_from_adc1))
    else $error("converter order");
  a_capture_gate: assert property (@(posedge vclk) disable iff (!rst_n)
    calm && pixel_valid |-> ctl_q[6]) else $error("capture while off");
endmodule

bind sfe_frontend sfe_frontend_assertions #(.PIX_W(PIX_W)) i_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_subaddr(reg_subaddr),
  .reg_wdata(reg_wdata), .vclk(vclk), .line_sync_input_pin(line_sync_input_pin),
  .frame_sync_input_pin(frame_sync_input_pin), .adc0_data(adc0_data),
  .adc1_data(adc1_data), .clamp_pulse(clamp_pulse),
  .gain_correction_pulse(gain_correction_pulse), .pixel_data(pixel_data),
  .pixel_valid(pixel_valid), .pixel_from_adc1(pixel_from_adc1));

`default_nettype wire

/* sfe_frontend_test.sv */
`timescale 1ns/100ps
`default_nettype none

module sfe_frontend_test import sfe_pkg::*; ;
  logic        ref_clk = 1'b0, vclk = 1'b0, rst_n = 1'b0, reg_wr_en = 1'b0;
  logic        start = 1'b0, hpol = 1'b0, vpol = 1'b0, first_exp = 1'b0, pv_p = 1'b0;
  logic [7:0]  reg_subaddr = 8'h00, reg_wdata = 8'h00, cur_ctl = 8'h00, line_no;
  logic        line_sync_input_pin, frame_sync_input_pin, busy, pixel_valid;
  logic        clamp_pulse, gain_correction_pulse, pixel_from_adc1;
  logic [23:0] adc0_data, adc1_data, pixel_data;
  int          fails = 0;
  int          n_checks = 0;
  int          cnt [8];
  logic [7:0]  tbl [20] = '{SFE_ADDR_VOFF_LO, 8'h02, SFE_ADDR_VOFF_HI, 8'h00,
    SFE_ADDR_VLEN_LO, 8'h03, SFE_ADDR_VLEN_HI, 8'h00, SFE_ADDR_HLEN_LO, 8'h06,
    SFE_ADDR_HLEN_HI, 8'h00, SFE_ADDR_CLAMP_ST, 8'h02, SFE_ADDR_CLAMP_END, 8'h06,
    SFE_ADDR_GAIN_ST, 8'h03, SFE_ADDR_GAIN_END, 8'h04};

  always #10 ref_clk = ~ref_clk;
  always #24 vclk = ~vclk;

  sfe_frontend #(.PIX_W(24)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_subaddr(reg_subaddr),
    .reg_wdata(reg_wdata), .vclk(vclk), .line_sync_input_pin(line_sync_input_pin),
    .frame_sync_input_pin(frame_sync_input_pin), .adc0_data(adc0_data),
    .adc1_data(adc1_data), .clamp_pulse(clamp_pulse),
    .gain_correction_pulse(gain_correction_pulse), .pixel_data(pixel_data),
    .pixel_valid(pixel_valid), .pixel_from_adc1(pixel_from_adc1));

  sfe_video_src i_src (
    .vclk(vclk), .start(start), .hpol(hpol), .vpol(vpol), .busy(busy), .line_no(line_no),
    .line_sync(line_sync_input_pin), .frame_sync(frame_sync_input_pin),
    .adc0(adc0_data), .adc1(adc1_data));

  // ----------------
  // Tasks
  // ----------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr_en <= 1'b1;
    reg_subaddr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
  endtask

  task automatic setup(input logic [7:0] ctl, input logic [11:0] hoff);
    wr(SFE_ADDR_GEN_CTRL, ctl);
    hpol <= ctl[0];
    vpol <= ctl[1];
    wr(SFE_ADDR_HOFF_LO, hoff[7:0]);
    wr(SFE_ADDR_HOFF_HI, {4'h0, hoff[11:8]});
    first_exp = ctl[4] ^ hoff[0];
    cur_ctl = ctl;
    repeat (40) @(posedge vclk);
  endtask

  // One line inside frame sync, then six lines; window lines are 2 to 4
  task automatic frame(input int n);
    for (int i = 0; i < 8; i++) cnt[i] = 0;
    @(posedge vclk);
    start <= 1'b1;
    repeat (2) @(posedge vclk);
    start <= 1'b0;
    for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge vclk);
    check("frame end", busy, 1'b0);
    repeat (300) @(posedge vclk);
    for (int i = 0; i < 8; i++) begin
      check("lines", cnt[i], (i >= 2 && i < 5) ? n : 0);
    end
    check("clamp idle", clamp_pulse, !cur_ctl[2]);
    check("gain idle", gain_correction_pulse, !cur_ctl[3]);
    $display("test with control %h done", cur_ctl);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Sampled mid-cycle so the link outputs have settled
  always @(negedge vclk) begin
    if (pixel_valid === 1'b1) begin
      cnt[line_no] = cnt[line_no] + 1;
      check("source", pixel_data[23:16], pixel_from_adc1 ? 8'hb1 : 8'ha0);
      if (pv_p !== 1'b1) check("first", pixel_from_adc1, first_exp);
    end
    pv_p = pixel_valid;
  end

  // ----------------
  // Sequence
  // ----------------
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    check("clamp reset", clamp_pulse, 1'b1);
    check("gain reset", gain_correction_pulse, 1'b1);
    check("valid reset", pixel_valid, 1'b0);
    for (int i = 0; i < 20; i += 2) wr(tbl[i], tbl[i + 1]);
    setup(8'h40, 12'h005);
    frame(6);
    setup(8'h5f, 12'h005);
    frame(6);
    setup(8'h40, 12'h105);
    frame(0);
    setup(8'h00, 12'h005);
    wr(8'h20, 8'h40);
    wr(8'h22, 8'h40);
    wr(8'h2f, 8'h40);
    frame(0);
    close_out;
  end

  initial begin
    repeat (30000) @(posedge ref_clk);
    fails++;
    close_out;
  end
endmodule

`default_nettype wire

/* sfe_pkg.sv */
package sfe_pkg;

  // ----------------------------------------------------------------
  // Subaddress map
  // ----------------------------------------------------------------
  localparam logic [7:0] SFE_ADDR_GEN_CTRL   = 8'h21;
  localparam logic [7:0] SFE_ADDR_VOFF_LO    = 8'h23;
  localparam logic [7:0] SFE_ADDR_VOFF_HI    = 8'h24;
  localparam logic [7:0] SFE_ADDR_HOFF_LO    = 8'h25;
  localparam logic [7:0] SFE_ADDR_HOFF_HI    = 8'h26;
  localparam logic [7:0] SFE_ADDR_VLEN_LO    = 8'h27;
  localparam logic [7:0] SFE_ADDR_VLEN_HI    = 8'h28;
  localparam logic [7:0] SFE_ADDR_HLEN_LO    = 8'h29;
  localparam logic [7:0] SFE_ADDR_HLEN_HI    = 8'h2a;
  localparam logic [7:0] SFE_ADDR_CLAMP_ST   = 8'h2b;
  localparam logic [7:0] SFE_ADDR_CLAMP_END  = 8'h2c;
  localparam logic [7:0] SFE_ADDR_GAIN_ST    = 8'h2d;
  localparam logic [7:0] SFE_ADDR_GAIN_END   = 8'h2e;

  // ----------------------------------------------------------------
  // General control field positions
  // ----------------------------------------------------------------
  localparam int SFE_BIT_HS_POL    = 0;
  localparam int SFE_BIT_VS_POL    = 1;
  localparam int SFE_BIT_CLAMP_POL = 2;
  localparam int SFE_BIT_GAIN_POL  = 3;
  localparam int SFE_BIT_ADC_SEQ   = 4;
  localparam int SFE_BIT_IN_EN     = 6;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int SFE_VW = 11;
  localparam int SFE_HW = 12;
  localparam int SFE_CFG_W = 8 + SFE_VW + SFE_HW + SFE_VW + SFE_HW + 4 * 8;

  localparam logic [7:0]        SFE_RST_GEN_CTRL = 8'h00;
  localparam logic [SFE_VW-1:0] SFE_RST_V        = 11'h000;
  localparam logic [SFE_HW-1:0] SFE_RST_H        = 12'h000;
  localparam logic [7:0]        SFE_RST_PULSE    = 8'h00;

endpackage

/* sfe_pulse_gen.sv */
`timescale 1ns/100ps
`default_nettype none

module sfe_pulse_gen import sfe_pkg::*; (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic set_hit,
  input  wire logic clr_hit,
  input  wire logic active_high,
  // Pin
  output var  logic pulse_out
);

  logic on_q;
  logic on_d;

  // Clear wins so an empty window gives no pulse
  assign on_d = clr_hit ? 1'b0 : (set_hit ? 1'b1 : on_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      on_q      <= 1'b0;
      pulse_out <= 1'b1;
    end else begin
      on_q      <= on_d;
      pulse_out <= active_high ? on_d : ~on_d;
    end
  end

endmodule

`default_nettype wire

/* sfe_sync2.sv */
`timescale 1ns/100ps
`default_nettype none

module sfe_sync2 import sfe_pkg::*; #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  if (W < 1) begin : g_bad_width
    $error("sfe_sync2: width must be at least 1");
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

`default_nettype wire

/* sfe_video_src.sv */
`timescale 1ns/100ps
`default_nettype none

module sfe_video_src import sfe_pkg::*; #(
  parameter int LINES = 6,
  parameter int HS_W  = 8,
  parameter int LINE  = 40
) (
  // Link clock and control
  input  wire logic        vclk,
  input  wire logic        start,
  input  wire logic        hpol,
  input  wire logic        vpol,
  output var  logic        busy,
  output var  logic [7:0]  line_no,
  // Pins
  output var  logic        line_sync,
  output var  logic        frame_sync,
  output var  logic [23:0] adc0,
  output var  logic [23:0] adc1
);
  logic [15:0] cnt_q;

  initial begin
    busy = 1'b0;
    line_no = 8'h00;
    line_sync = 1'b1;
    frame_sync = 1'b1;
    cnt_q = 16'h0000;
    adc0 = 24'h000000;
    adc1 = 24'h000000;
  end

  // Samples change every cycle so a misaligned capture shows
  always @(posedge vclk) begin
    cnt_q <= cnt_q + 16'h0001;
    adc0 <= {8'ha0, cnt_q};
    adc1 <= {8'hb1, cnt_q};
  end

  always begin
    @(posedge vclk);
    if (start) begin
      busy <= 1'b1;
      line_no <= 8'h00;
      // A line inside frame sync shows which frame sync edge starts the frame
      frame_sync <= vpol;
      line_sync <= hpol;
      repeat (HS_W) @(posedge vclk);
      line_sync <= ~hpol;
      repeat (8) @(posedge vclk);
      frame_sync <= ~vpol;
      repeat (10) @(posedge vclk);
      for (int l = 1; l <= LINES; l++) begin
        line_sync <= hpol;
        repeat (HS_W) @(posedge vclk);
        line_sync <= ~hpol;
        line_no <= 8'(l);
        repeat (LINE - HS_W) @(posedge vclk);
      end
      busy <= 1'b0;
    end else begin
      line_sync <= ~hpol;
      frame_sync <= ~vpol;
    end
  end
endmodule

`default_nettype wire
